/* File: inc/pxb_pkg.sv */
/*
 * Constants for the priority pin crossbar: register addresses, pages,
 * field positions, reset values, fixed pin numbers and function indices.
 * Assumes a core register bus with an 8-bit address and a 4-bit page.
 */
package pxb_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_ROUTE_FIRST = 8'hE1;
    localparam logic [7:0] ADDR_ROUTE_SECOND = 8'hE2;
    localparam logic [7:0] ADDR_ROUTE_GLOBAL = 8'hE3;
    localparam logic [3:0] PAGE_LOW = 4'h0;
    localparam logic [3:0] PAGE_HIGH = 4'hF;
    localparam logic [7:0] RST_ROUTE_FIRST = 8'h00;
    localparam logic [7:0] RST_ROUTE_SECOND = 8'h00;
    localparam logic [7:0] RST_ROUTE_GLOBAL = 8'h00;
    localparam logic [7:0] MASK_ROUTE_SECOND = 8'h7F;
    localparam logic [7:0] MASK_ROUTE_GLOBAL = 8'hC0;
    // ****************************************
    // field positions
    // ****************************************
    localparam int BIT_UART = 0;
    localparam int BIT_SERIAL_A = 1;
    localparam int BIT_TWOWIRE = 2;
    localparam int BIT_SYSCLK = 3;
    localparam int BIT_CMP_A = 4;
    localparam int BIT_CMP_A_ASYNC = 5;
    localparam int BIT_CMP_B = 6;
    localparam int BIT_CMP_B_ASYNC = 7;
    localparam int BIT_CNT_LSB = 0;
    localparam int BIT_CLKIN = 3;
    localparam int BIT_TIMER_A = 4;
    localparam int BIT_TIMER_B = 5;
    localparam int BIT_SERIAL_B = 6;
    localparam int BIT_GLOBAL_EN = 6;
    localparam int BIT_PULLUP_OFF = 7;
    localparam logic [2:0] CNT_RESERVED = 3'h7;
    // ****************************************
    // pins and functions
    // ****************************************
    localparam int NUM_PINS = 24;
    localparam int NUM_CAND = 23;
    localparam int NUM_FN = 26;
    localparam int PIN_UART_TX = 4;
    localparam int PIN_UART_RX = 5;
    localparam int PIN_SERIAL_B = 16;
    localparam int PIN_IRQ_HI = 14;
    localparam int FN_UART_TX = 0;
    localparam int FN_UART_RX = 1;
    localparam int FN_SB_SCK = 2;
    localparam int FN_SB_NSS = 5;
    localparam int FN_SA_SCK = 6;
    localparam int FN_SA_NSS = 9;
    localparam int FN_SDA = 10;
    localparam int FN_SCL = 11;
    localparam int FN_CMP_A = 12;
    localparam int FN_CMP_A_ASYNC = 13;
    localparam int FN_CMP_B = 14;
    localparam int FN_CMP_B_ASYNC = 15;
    localparam int FN_SYSCLK = 16;
    localparam int FN_COUNTER_MODULE_OUTPUT_ZERO = 17;
    localparam int FN_CLKIN = 23;
    localparam int FN_TIMER_A = 24;
    localparam int FN_TIMER_B = 25;
    localparam int FN_FIRST_FREE = 6;
    localparam int NUM_CEX = 6;
endpackage

/* File: logic/pxb_crossbar.sv */
/*
 * Priority pin crossbar for ports 0 to 2: route-enable registers on the
 * core register bus, priority pin assignment, pad driver and pull-up
 * control, routed inputs and external-interrupt pin sampling.
 * Assumes pad values, per-pin masks and latches arrive synchronous to clk_i.
 */
`timescale 1ns/1ps

// What this block does
// - only unskipped pins P0.0-P2.6 are candidates
// - uart fixed on P0.4 and P0.5
// - serial b on P2.0-P2.2, P2.3 when four-wire
// - remaining functions take lowest free candidate
// - pass over taken or skipped pins
// - all drivers off while crossbar disabled
// - two-wire pins forced open-drain
// - serial a select only in four-wire mode
// - first register bit map, bit7 down to bit0
// - second register bits 6 to 3
// - counter module field routes N outputs, 7 reserved
// - pull-ups on unless off bit, analog, or pin driven low
// - global bit 6 enables crossbar
// - unused bits read zero, ignore writes
// - memory interface pins stay outside this crossbar
// - event capture on digital pins, not analog
// - interrupt pin choices and match range
// - registers visible on pages 0x0 and 0xF
// - pull-up off bit disables all pull-ups
// - mode bit 1 push-pull, 0 open-drain
// - analog pin reads 0, no pull-up
module pxb_crossbar #(
    parameter int NPINS = pxb_pkg::NUM_PINS,
    parameter int NFN = pxb_pkg::NUM_FN
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // core register bus
    input wire logic [7:0] sfr_addr_i,
    input wire logic [3:0] sfr_page_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // per-pin configuration from the port registers
    input wire logic [NPINS-1:0] pin_bypass_mask_i,
    input wire logic [NPINS-1:0] pin_output_mode_bits_i,
    input wire logic [NPINS-1:0] pin_analog_select_bits_i,
    input wire logic [NPINS-1:0] port_latch_i,
    // peripheral modes
    input wire logic serial_a_four_wire_i,
    input wire logic serial_b_four_wire_i,
    input wire logic [2:0] ext_irq_a_pin_sel_i,
    input wire logic [2:0] ext_irq_b_pin_sel_i,
    // peripheral side
    input wire logic [NFN-1:0] fn_out_i,
    input wire logic [NFN-1:0] fn_drive_i,
    output logic [NFN-1:0] fn_in_o,
    output logic [NFN-1:0] fn_routed_o,
    output logic ext_irq_a_o,
    output logic ext_irq_b_o,
    // pad side
    input wire logic [NPINS-1:0] pad_in_i,
    output logic [NPINS-1:0] pad_out_o,
    output logic [NPINS-1:0] pad_oe_b_o,
    output logic [NPINS-1:0] pullup_en_o,
    output logic [NPINS-1:0] pin_read_o
);
    // ****************************************
    // registers
    // ****************************************
    logic [7:0] route_enables_first;
    logic [7:0] route_enables_second;
    logic [7:0] route_global_control;
    logic page_ok;
    logic route_global_enable;
    logic pullup_global_off;
    logic [2:0] counter_array_module_count;

    assign page_ok = (sfr_page_i == pxb_pkg::PAGE_LOW) || (sfr_page_i == pxb_pkg::PAGE_HIGH);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            route_enables_first <= pxb_pkg::RST_ROUTE_FIRST;
            route_enables_second <= pxb_pkg::RST_ROUTE_SECOND;
            route_global_control <= pxb_pkg::RST_ROUTE_GLOBAL;
        end else if (sfr_wr_i && page_ok) begin
            unique case (sfr_addr_i)
                pxb_pkg::ADDR_ROUTE_FIRST: route_enables_first <= sfr_wdata_i;
                pxb_pkg::ADDR_ROUTE_SECOND: begin
                    route_enables_second <= sfr_wdata_i & pxb_pkg::MASK_ROUTE_SECOND;
                end
                pxb_pkg::ADDR_ROUTE_GLOBAL: begin
                    route_global_control <= sfr_wdata_i & pxb_pkg::MASK_ROUTE_GLOBAL;
                end
                default: ;
            endcase
        end
    end

    // read data lags the address by one clock; unmapped reads give zero
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (!page_ok) begin
            sfr_rdata_o <= 8'h00;
        end else begin
            unique case (sfr_addr_i)
                pxb_pkg::ADDR_ROUTE_FIRST: sfr_rdata_o <= route_enables_first;
                pxb_pkg::ADDR_ROUTE_SECOND: sfr_rdata_o <= route_enables_second;
                pxb_pkg::ADDR_ROUTE_GLOBAL: sfr_rdata_o <= route_global_control;
                default: sfr_rdata_o <= 8'h00;
            endcase
        end
    end

    assign route_global_enable = route_global_control[pxb_pkg::BIT_GLOBAL_EN];
    assign pullup_global_off = route_global_control[pxb_pkg::BIT_PULLUP_OFF];
    assign counter_array_module_count = route_enables_second[pxb_pkg::BIT_CNT_LSB +: 3];

    // ****************************************
    // function enables
    // ****************************************
    logic [NFN-1:0] fn_en;

    always_comb begin
        fn_en = '0;
        fn_en[pxb_pkg::FN_UART_TX] = route_enables_first[pxb_pkg::BIT_UART];
        fn_en[pxb_pkg::FN_UART_RX] = route_enables_first[pxb_pkg::BIT_UART];
        for (int k = 0; k < 3; k++) begin
            fn_en[pxb_pkg::FN_SA_SCK + k] = route_enables_first[pxb_pkg::BIT_SERIAL_A];
            fn_en[pxb_pkg::FN_SB_SCK + k] = route_enables_second[pxb_pkg::BIT_SERIAL_B];
        end
        // select pin only in four-wire mode
        fn_en[pxb_pkg::FN_SA_NSS] = route_enables_first[pxb_pkg::BIT_SERIAL_A]
            && serial_a_four_wire_i;
        fn_en[pxb_pkg::FN_SB_NSS] = route_enables_second[pxb_pkg::BIT_SERIAL_B]
            && serial_b_four_wire_i;
        fn_en[pxb_pkg::FN_SDA] = route_enables_first[pxb_pkg::BIT_TWOWIRE];
        fn_en[pxb_pkg::FN_SCL] = route_enables_first[pxb_pkg::BIT_TWOWIRE];
        fn_en[pxb_pkg::FN_CMP_A] = route_enables_first[pxb_pkg::BIT_CMP_A];
        fn_en[pxb_pkg::FN_CMP_A_ASYNC] = route_enables_first[pxb_pkg::BIT_CMP_A_ASYNC];
        fn_en[pxb_pkg::FN_CMP_B] = route_enables_first[pxb_pkg::BIT_CMP_B];
        fn_en[pxb_pkg::FN_CMP_B_ASYNC] = route_enables_first[pxb_pkg::BIT_CMP_B_ASYNC];
        fn_en[pxb_pkg::FN_SYSCLK] = route_enables_first[pxb_pkg::BIT_SYSCLK];
        // counter module outputs, reserved code routes none
        for (int k = 0; k < pxb_pkg::NUM_CEX; k++) begin
            fn_en[pxb_pkg::FN_COUNTER_MODULE_OUTPUT_ZERO + k] = (counter_array_module_count != pxb_pkg::CNT_RESERVED)
                && (counter_array_module_count > 3'(k));
        end
        fn_en[pxb_pkg::FN_CLKIN] = route_enables_second[pxb_pkg::BIT_CLKIN];
        fn_en[pxb_pkg::FN_TIMER_A] = route_enables_second[pxb_pkg::BIT_TIMER_A];
        fn_en[pxb_pkg::FN_TIMER_B] = route_enables_second[pxb_pkg::BIT_TIMER_B];
    end

    // ****************************************
    // priority assignment
    // ****************************************
    logic [NPINS-1:0] taken;
    logic found;
    logic [4:0] next_fn_pin [NFN];
    logic [NFN-1:0] next_fn_ok;
    logic [4:0] next_pin_fn [NPINS];
    logic [NPINS-1:0] next_pin_own;
    logic [4:0] fn_pin [NFN];
    logic [NFN-1:0] fn_ok;
    logic [4:0] pin_fn [NPINS];
    logic [NPINS-1:0] pin_own;

    // a full linear search per function; deep logic, but it settles
    // within one clock at this rate and keeps the priority obvious
    always_comb begin
        taken = '0;
        found = 1'b0;
        next_fn_ok = '0;
        next_pin_own = '0;
        next_fn_pin = '{default: 5'h00};
        next_pin_fn = '{default: 5'h00};
        if (fn_en[pxb_pkg::FN_UART_TX]) begin
            next_fn_pin[pxb_pkg::FN_UART_TX] = 5'(pxb_pkg::PIN_UART_TX);
            next_fn_pin[pxb_pkg::FN_UART_RX] = 5'(pxb_pkg::PIN_UART_RX);
        end
        for (int k = 0; k < 4; k++) begin
            if (fn_en[pxb_pkg::FN_SB_SCK + k]) begin
                next_fn_pin[pxb_pkg::FN_SB_SCK + k] = 5'(pxb_pkg::PIN_SERIAL_B + k);
            end
        end
        for (int f = 0; f < pxb_pkg::FN_FIRST_FREE; f++) begin
            if (fn_en[f]) begin
                next_fn_ok[f] = 1'b1;
                taken[next_fn_pin[f]] = 1'b1;
                next_pin_own[next_fn_pin[f]] = 1'b1;
                next_pin_fn[next_fn_pin[f]] = 5'(f);
            end
        end
        // lowest free candidate in priority order
        for (int f = pxb_pkg::FN_FIRST_FREE; f < NFN; f++) begin
            found = 1'b0;
            for (int p = 0; p < pxb_pkg::NUM_CAND; p++) begin
                // pass over skipped or taken pins
                if (fn_en[f] && !found && !pin_bypass_mask_i[p] && !taken[p]) begin
                    found = 1'b1;
                    taken[p] = 1'b1;
                    next_fn_ok[f] = 1'b1;
                    next_fn_pin[f] = 5'(p);
                    next_pin_own[p] = 1'b1;
                    next_pin_fn[p] = 5'(f);
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fn_ok <= '0;
            pin_own <= '0;
            fn_pin <= '{default: 5'h00};
            pin_fn <= '{default: 5'h00};
        end else begin
            fn_ok <= next_fn_ok;
            pin_own <= next_pin_own;
            fn_pin <= next_fn_pin;
            pin_fn <= next_pin_fn;
        end
    end

    // ****************************************
    // pad drivers and pull-ups
    // ****************************************
    logic [NPINS-1:0] next_pad_out;
    logic [NPINS-1:0] next_oe_b;
    logic [NPINS-1:0] pin_dig_in;
    logic push_pull;
    logic wants_drive;

    assign pin_dig_in = pad_in_i & pin_analog_select_bits_i;

    always_comb begin
        next_pad_out = '1;
        next_oe_b = '1;
        push_pull = 1'b0;
        wants_drive = 1'b0;
        for (int p = 0; p < NPINS; p++) begin
            push_pull = pin_output_mode_bits_i[p];
            if (pin_own[p]) begin
                next_pad_out[p] = fn_out_i[pin_fn[p]];
                wants_drive = fn_drive_i[pin_fn[p]];
                if (pin_fn[p] == 5'(pxb_pkg::FN_SDA) || pin_fn[p] == 5'(pxb_pkg::FN_SCL)) begin
                    push_pull = 1'b0;
                end
            end else begin
                next_pad_out[p] = port_latch_i[p];
                wants_drive = 1'b1;
            end
            next_oe_b[p] = !(route_global_enable && wants_drive
                && (push_pull || !next_pad_out[p]));
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pad_out_o <= '1;
            pad_oe_b_o <= '1;
        end else begin
            pad_out_o <= next_pad_out;
            pad_oe_b_o <= next_oe_b;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pullup_en_o <= '1;
        end else begin
            pullup_en_o <= {NPINS{!pullup_global_off}} & pin_analog_select_bits_i
                & ~(~next_oe_b & ~next_pad_out);
        end
    end

    // ****************************************
    // routed inputs and event capture pins
    // ****************************************
    // only ports 0 to 2 pass through here
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fn_in_o <= '1;
            fn_routed_o <= '0;
            pin_read_o <= '0;
        end else begin
            pin_read_o <= pin_dig_in;
            fn_routed_o <= fn_ok;
            for (int f = 0; f < NFN; f++) begin
                fn_in_o[f] <= fn_ok[f] ? pin_dig_in[fn_pin[f]] : 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_irq_a_o <= 1'b0;
            ext_irq_b_o <= 1'b0;
        end else begin
            ext_irq_a_o <= (ext_irq_a_pin_sel_i[2:1] == 2'h3)
                ? pin_dig_in[pxb_pkg::PIN_IRQ_HI + 32'(ext_irq_a_pin_sel_i[0])]
                : pin_dig_in[ext_irq_a_pin_sel_i];
            // the second source cannot use P0.5; that code reads low
            ext_irq_b_o <= (ext_irq_b_pin_sel_i[2:1] == 2'h3)
                ? pin_dig_in[pxb_pkg::PIN_IRQ_HI + 32'(ext_irq_b_pin_sel_i[0])]
                : (ext_irq_b_pin_sel_i != 3'h5) && pin_dig_in[ext_irq_b_pin_sel_i];
        end
    end
endmodule

/* File: bench/pxb_crossbar_props.sv */
/* Concurrent checks on the pin crossbar ports.
   Assumes one clock domain and the port timing of the crossbar hand-over. */
`timescale 1ns/1ps
module pxb_crossbar_props #(
    parameter int NPINS = 24,
    parameter int NFN = 26
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register bus
    input wire logic [7:0] sfr_addr_i,
    input wire logic [3:0] sfr_page_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    // pins and functions
    input wire logic [NPINS-1:0] pin_analog_select_bits_i,
    input wire logic [NPINS-1:0] pad_in_i,
    input wire logic [2:0] ext_irq_a_pin_sel_i,
    input wire logic ext_irq_a_o,
    input wire logic [NFN-1:0] fn_routed_o,
    input wire logic [NPINS-1:0] pad_oe_b_o,
    input wire logic [NPINS-1:0] pullup_en_o,
    input wire logic [NPINS-1:0] pin_read_o
);
    // ****************************************
    // mirror of the global control bits
    // ****************************************
    logic page_ok;
    logic [2:0] en_hist;
    logic [2:0] off_hist;
    logic past_valid;
    logic [4:0] irq_pin;
    logic irq_lvl;
    assign page_ok = (sfr_page_i == 4'h0) || (sfr_page_i == 4'hF);
    // selects 6 and 7 land on the upper port pins 14 and 15
    assign irq_pin = (ext_irq_a_pin_sel_i < 3'h6) ? {2'h0, ext_irq_a_pin_sel_i}
                                                  : {2'h1, ext_irq_a_pin_sel_i};
    assign irq_lvl = pad_in_i[irq_pin] & pin_analog_select_bits_i[irq_pin];
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            en_hist <= 3'h0;
            off_hist <= 3'h0;
            past_valid <= 1'b0;
        end else begin
            past_valid <= 1'b1;
            en_hist[2:1] <= en_hist[1:0];
            off_hist[2:1] <= off_hist[1:0];
            if (sfr_wr_i && page_ok && sfr_addr_i == 8'hE3) begin
                en_hist[0] <= sfr_wdata_i[6];
                off_hist[0] <= sfr_wdata_i[7];
            end
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    glob_off_a: assert property (en_hist == 3'h0 |-> &pad_oe_b_o)
        else $error("pad driven while crossbar disabled");
    pullup_off_a: assert property (&off_hist |-> pullup_en_o == '0)
        else $error("pull-up on while globally off");
    global_read_a: assert property (page_ok && sfr_addr_i == 8'hE3
        |=> sfr_rdata_o[5:0] == 6'h00)
        else $error("unused control bits read nonzero");
    second_read_a: assert property (page_ok && sfr_addr_i == 8'hE2 |=> !sfr_rdata_o[7])
        else $error("unused route bit reads nonzero");
    page_refuse_a: assert property (!page_ok |=> sfr_rdata_o == 8'h00)
        else $error("register visible on wrong page");
    uart_route_a: assert property ((sfr_wr_i && page_ok && sfr_addr_i == 8'hE1
        && sfr_wdata_i[0]) ##1 !sfr_wr_i |=> ##1 fn_routed_o[1:0] == 2'h3)
        else $error("uart not routed after enable");
    analog_read_a: assert property (1'b1 |=> pin_read_o
        == ($past(pad_in_i) & $past(pin_analog_select_bits_i)))
        else $error("pin read wrong for analog or digital pin");
    analog_pullup_a: assert property (past_valid && $stable(pin_analog_select_bits_i)
        |-> (pullup_en_o & ~pin_analog_select_bits_i) == '0)
        else $error("pull-up on an analog pin");
    irq_pin_a: assert property (1'b1 |=> ext_irq_a_o == $past(irq_lvl))
        else $error("interrupt level from wrong pin");
endmodule

bind pxb_crossbar pxb_crossbar_props #(.NPINS(NPINS), .NFN(NFN)) pxb_crossbar_props_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .sfr_addr_i(sfr_addr_i), .sfr_page_i(sfr_page_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .pin_analog_select_bits_i(pin_analog_select_bits_i), .pad_in_i(pad_in_i),
    .ext_irq_a_pin_sel_i(ext_irq_a_pin_sel_i), .ext_irq_a_o(ext_irq_a_o),
    .fn_routed_o(fn_routed_o), .pad_oe_b_o(pad_oe_b_o), .pullup_en_o(pullup_en_o),
    .pin_read_o(pin_read_o));

/* File: bench/pxb_pad_world.sv */
/* Board seen from the pads: resolves each pad level.
   Assumes active-low output enables and a board level on floating pins. */
`timescale 1ns/1ps
module pxb_pad_world (
    // pad side of the crossbar
    input wire logic [23:0] pad_out_i,
    input wire logic [23:0] pad_oe_b_i,
    input wire logic [23:0] pullup_en_i,
    // level of the board on pins nobody drives or pulls
    input wire logic [23:0] ext_level_i,
    output logic [23:0] pad_in_o
);
    // ****************************************
    // wire resolution
    // ****************************************
    // driven pad follows
    always_comb begin
        for (int p = 0; p < 24; p++) begin
            if (!pad_oe_b_i[p]) begin
                pad_in_o[p] = pad_out_i[p];
            end else if (pullup_en_i[p]) begin
                pad_in_o[p] = 1'b1;
            end else begin
                pad_in_o[p] = ext_level_i[p];
            end
        end
    end
endmodule

/* File: bench/testbench.sv */
/* Bench for the pin crossbar: register tasks and a table of placements.
   Assumes the pad model closes the loop from pad drive back to pad level. */
`timescale 1ns/1ps
module testbench;
    // ****************************************
    // signals and tables
    // ****************************************
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [3:0] page = 4'h0;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [23:0] skip = '0, mode = '1, dig = '1, latch = 24'h5A5A5F, lvl = 24'h3C3C3C;
    logic [23:0] pin_in, pout, poe_b, pull, pread;
    logic [25:0] fn_out = 26'h2C3A5E1, fn_drive = 26'h07FFFFD, fn_in, routed;
    logic fa = 1'b0, fb = 1'b0;
    logic eia, eib;
    logic [2:0] irq_a = 3'h0;
    int mismatches = 0, comparisons = 0, cycles = 0, i;
    logic [7:0] e1_t [7] = '{8'h01, 8'h01, 8'hFF, 8'h06, 8'hFE, 8'hFE, 8'hFF};
    logic [7:0] e2_t [7] = '{8'h00, 8'h00, 8'h7F, 8'h46, 8'h3E, 8'h3E, 8'h7E};
    logic [7:0] e3_t [7] = '{8'h00, 8'h40, 8'h40, 8'hC0, 8'h40, 8'h40, 8'h40};
    // analog pins are skipped, open-drain and latched high
    logic [23:0] skip_t [7] = '{24'h0, 24'h0, 24'h00000C, 24'h555555, 24'h0, 24'h0, 24'h0};
    logic [23:0] mode_t [7] = '{'1, '1, 24'hAAAAA2, '1, 24'h0F0F0F, 24'h0F0F0F, '1};
    logic [23:0] dig_t [7] = '{'1, '1, 24'hFFFFF3, '1, '1, '1, '1};
    logic [1:0] wf_t [7] = '{2'h0, 2'h0, 2'h3, 2'h0, 2'h2, 2'h0, 2'h3};

    pxb_crossbar pxb_crossbar_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .sfr_addr_i(addr),
        .sfr_page_i(page), .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
        .pin_bypass_mask_i(skip), .pin_output_mode_bits_i(mode),
        .pin_analog_select_bits_i(dig), .port_latch_i(latch), .serial_a_four_wire_i(fa),
        .serial_b_four_wire_i(fb), .ext_irq_a_pin_sel_i(irq_a), .ext_irq_b_pin_sel_i(~irq_a),
        .fn_out_i(fn_out), .fn_drive_i(fn_drive), .fn_in_o(fn_in), .fn_routed_o(routed),
        .ext_irq_a_o(eia), .ext_irq_b_o(eib), .pad_in_i(pin_in), .pad_out_o(pout),
        .pad_oe_b_o(poe_b), .pullup_en_o(pull), .pin_read_o(pread));
    pxb_pad_world pxb_pad_world_i (.pad_out_i(pout), .pad_oe_b_i(poe_b), .pullup_en_i(pull),
        .ext_level_i(lvl), .pad_in_o(pin_in));

    initial forever #20 clk_i = ~clk_i;

    // ****************************************
    // tasks
    // ****************************************
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] pg, input logic [7:0] ad, input logic [7:0] d);
        @(negedge clk_i);
        page = pg;
        addr = ad;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_i);
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] pg, input logic [7:0] ad, input logic [7:0] exp);
        @(negedge clk_i);
        page = pg;
        addr = ad;
        @(negedge clk_i);
        chk({24'h0, rdata}, {24'h0, exp});
    endtask
    // expected placement worked out from the priority order
    task automatic check_map(input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] e3);
        int own [24];
        int p, f;
        logic [25:0] en, exp_rt, exp_in;
        logic [23:0] exp_oe_b, exp_pu;
        logic v, d, drv;
        logic [2:0] sb;
        en = {e2[5], e2[4], e2[3], 6'h0, e1[3], e1[7], e1[6], e1[5], e1[4], {2{e1[2]}},
              e1[1] & fa, {3{e1[1]}}, e2[6] & fb, {3{e2[6]}}, {2{e1[0]}}};
        for (f = 0; f < 6; f++) en[17 + f] = (e2[2:0] != 3'h7) && (f < e2[2:0]);
        for (p = 0; p < 24; p++) own[p] = -1;
        for (f = 0; f < 6; f++) if (en[f]) own[(f < 2) ? 4 + f : 14 + f] = f;
        for (f = 6; f < 26; f++) begin
            p = 0;
            while (p < 23 && (skip[p] || own[p] >= 0)) p++;
            if (en[f] && p < 23) own[p] = f;
        end
        exp_rt = '0;
        exp_in = '1;
        for (p = 0; p < 24; p++) begin
            f = own[p];
            if (f >= 0) exp_rt[f] = 1'b1;
            if (f >= 0) exp_in[f] = pin_in[p] & dig[p];
            v = (f >= 0) ? fn_out[f] : latch[p];
            drv = (f >= 0) ? fn_drive[f] : 1'b1;
            d = e3[6] && drv && ((mode[p] && f != 10 && f != 11) || !v);
            exp_oe_b[p] = !d;
            exp_pu[p] = !e3[7] && dig[p] && !(d && !v);
            if (d) chk({31'h0, pout[p]}, {31'h0, v});
        end
        p = (irq_a > 3'h5) ? 8 + irq_a : irq_a;
        chk({31'h0, eia}, {31'h0, pin_in[p] & dig[p]});
        sb = ~irq_a;
        p = (sb > 3'h5) ? 8 + sb : sb;
        chk({31'h0, eib}, {31'h0, sb != 3'h5 && pin_in[p] && dig[p]});
        chk({8'h0, poe_b}, {8'h0, exp_oe_b});
        chk({6'h0, routed}, {6'h0, exp_rt});
        chk({6'h0, fn_in}, {6'h0, exp_in});
        chk({8'h0, pull}, {8'h0, exp_pu});
        chk({8'h0, pread}, {8'h0, pin_in & dig});
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            finish_test;
        end
    end
    initial begin
        repeat (12) @(negedge clk_i);
        rst_b_i = 1'b1;
        rd_chk(4'h0, 8'hE1, 8'h00);
        rd_chk(4'h0, 8'hE2, 8'h00);
        rd_chk(4'h0, 8'hE3, 8'h00);
        wr_reg(4'hF, 8'hE3, 8'hFF);
        rd_chk(4'h0, 8'hE3, 8'hC0);
        wr_reg(4'h0, 8'hE2, 8'hFF);
        rd_chk(4'hF, 8'hE2, 8'h7F);
        wr_reg(4'h1, 8'hE1, 8'hFF);
        rd_chk(4'hF, 8'hE1, 8'h00);
        rd_chk(4'h0, 8'hE4, 8'h00);
        for (i = 0; i < 7; i++) begin
            @(negedge clk_i);
            skip = skip_t[i];
            mode = mode_t[i];
            dig = dig_t[i];
            {fa, fb} = wf_t[i];
            irq_a = i[2:0];
            wr_reg(i[0] ? 4'hF : 4'h0, 8'hE1, e1_t[i]);
            wr_reg(4'h0, 8'hE2, e2_t[i]);
            wr_reg(4'hF, 8'hE3, e3_t[i]);
            repeat (4) @(negedge clk_i);
            check_map(e1_t[i], e2_t[i], e3_t[i]);
        end
        finish_test;
    end
endmodule
